// *** core/gat_recorder.sv ***
// Gated sample recorder with timestamp counter and APB register access.
// Functional notes
// - Recording starts a fixed start delay after gate opening, chosen by setup.
// - Active synchronization adds two samples to every start delay.
// - Negative delay shows samples before and including the gate event.
// - After gate end, recording also stops once it has reached the gate length less the shortfall table.
// - Only the twelve gate modes are accepted; each has start and end events.
// - External edge gating opens on one edge and closes on the opposite.
// - External width gating opens after a long enough level, closes on its edge.
// - Channel edge gating opens on level crossing, closes on reverse crossing.
// - Channel width gating opens after a long enough level, closes on crossing back.
// - Window gating opens on entering or leaving the band, closes on the reverse.
// - Window width gating needs the entry or exit to persist past the width.
// - A wide resettable counter advances once per sample.
// - Every trigger event copies the counter into the timestamp store; one on the sample where recording stops is stored as an end entry.
// - Start and end of each recorded segment are timestamped.
// - The timestamp store is a 64K entry FIFO readable while recording.
// - The counter runs at the non-interlaced sample rate.
// - Standard mode pauses between gates and stops at the total sample count.
// - Gate end takes effect on an eight-sample boundary, at most seven extra.
// - No pretrigger samples and no post-trigger counter in gated recording.
// - FIFO mode ignores the total count and runs until software stops it.
`timescale 1ns/1ps
module gat_recorder (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic sample_en_i,
  input wire logic [7:0] sample_i,
  input wire logic ext_trig_i,
  output logic rec_valid_o,
  output logic [7:0] rec_data_o,
  output logic gate_o,
  output logic done_o
);

  // Start delay for the present setup.
  function automatic logic signed [6:0] start_delay(input logic two_ch, input logic [1:0] band,
                                                    input logic ext, input logic sync);
    logic signed [6:0] d;
    d = 7'sh00;
    if (!two_ch)
    begin
      if (band == 2'h0)
      begin
        d = ext ? gat_pkg::SD_1_LO_EXT : gat_pkg::SD_1_LO_INT;
      end
      else if (band == 2'h1)
      begin
        d = ext ? gat_pkg::SD_1_MID_EXT : gat_pkg::SD_1_MID_INT;
      end
      else
      begin
        d = ext ? gat_pkg::SD_1_HI_EXT : gat_pkg::SD_1_HI_INT;
      end
    end
    else if (band == 2'h0)
    begin
      d = ext ? gat_pkg::SD_2_LO_EXT : gat_pkg::SD_2_LO_INT;
    end
    else
    begin
      d = ext ? gat_pkg::SD_2_HI_EXT : gat_pkg::SD_2_HI_INT;
    end
    if (sync)
    begin
      d = d + gat_pkg::SD_SYNC_ADD;
    end
    return d;
  endfunction

  // Address decode, used only for the error answer; the read mux decodes the address itself.
  function automatic logic addr_hit(input logic [7:0] a);
    return (a == gat_pkg::ADDR_CTRL) || (a == gat_pkg::ADDR_MODE) ||
           (a == gat_pkg::ADDR_LEVEL) || (a == gat_pkg::ADDR_WIDTH) ||
           (a == gat_pkg::ADDR_TOTAL) || (a == gat_pkg::ADDR_STATUS) ||
           (a == gat_pkg::ADDR_TS_LO) || (a == gat_pkg::ADDR_TS_HI) ||
           (a == gat_pkg::ADDR_TS_COUNT);
  endfunction

  gat_pkg::gat_core_s r;
  gat_pkg::gat_core_s n;
  gat_pkg::gat_ts_s push_data;
  gat_pkg::gat_ts_s head;
  logic push;
  logic pop;
  logic [16:0] ts_count;
  logic full;
  logic empty;
  logic above;
  logic inwin;
  logic cond;
  logic lp;
  logic mode_ok;
  logic ext_src;
  logic active;
  logic start_ev;
  logic end_ev;
  logic [15:0] wcnt_inc;
  logic [31:0] shortfall;
  logic signed [6:0] delay;
  logic [31:0] rdata;
  logic [31:0] seg_inc;
  logic [31:0] tot_inc;
  logic setup;
  logic access;

  assign above = sample_i > r.lvl_lo;
  assign inwin = (sample_i > r.lvl_lo) && (sample_i < r.lvl_hi);
  assign mode_ok = r.mode <= 4'hB;
  assign ext_src = r.mode <= 4'h3;
  assign active = r.run && r.gate_en && mode_ok;
  assign delay = start_delay(r.two_ch, r.band, ext_src, r.sync);
  assign shortfall = r.two_ch ? ((r.band == 2'h0) ? gat_pkg::SHORT_2_LO : gat_pkg::SHORT_2_HI)
                              : ((r.band == 2'h0) ? gat_pkg::SHORT_1_LO : gat_pkg::SHORT_1_HI);
  assign wcnt_inc = (r.wcnt == 16'hFFFF) ? r.wcnt : r.wcnt + 16'h0001;
  assign seg_inc = r.seg + 32'h00000001;
  assign tot_inc = r.rec_total + 32'h00000001;
  assign setup = psel_i && !penable_i;
  assign access = psel_i && penable_i && r.pready;

  // Gate condition per mode; width modes are qualified separately.
  always_comb
  begin
    cond = 1'b0;
    lp = 1'b0;
    case (r.mode)
      gat_pkg::ext_rising_gate: cond = ext_trig_i;
      gat_pkg::ext_falling_gate: cond = !ext_trig_i;
      gat_pkg::ext_high_width_gate:
      begin
        cond = ext_trig_i;
        lp = 1'b1;
      end
      gat_pkg::ext_low_width_gate:
      begin
        cond = !ext_trig_i;
        lp = 1'b1;
      end
      gat_pkg::chan_rising_gate: cond = above;
      gat_pkg::chan_falling_gate: cond = !above;
      gat_pkg::chan_above_width_gate:
      begin
        cond = above;
        lp = 1'b1;
      end
      gat_pkg::chan_below_width_gate:
      begin
        cond = !above;
        lp = 1'b1;
      end
      gat_pkg::window_enter_gate: cond = inwin;
      gat_pkg::window_leave_gate: cond = !inwin;
      gat_pkg::window_enter_width_gate:
      begin
        cond = inwin;
        lp = 1'b1;
      end
      gat_pkg::window_leave_width_gate:
      begin
        cond = !inwin;
        lp = 1'b1;
      end
      default:
      begin
        cond = 1'b0;
        lp = 1'b0;
      end
    endcase
  end

  // Events are looked at only on sample ticks, so widths count samples.
  assign start_ev = sample_en_i && active && !r.gate && cond &&
                    (lp ? (wcnt_inc > r.width) : !r.cond_prev);
  assign end_ev = sample_en_i && active && r.gate && !cond;

  always_comb
  begin
    rdata = 32'h00000000;
    if (paddr_i == gat_pkg::ADDR_CTRL)
    begin
      rdata[gat_pkg::CTRL_GATE_BIT] = r.gate_en;
      rdata[gat_pkg::CTRL_FIFO_BIT] = r.fifo_mode;
      rdata[gat_pkg::CTRL_RUN_BIT] = r.run;
      rdata[gat_pkg::CTRL_TWO_CH_BIT] = r.two_ch;
      rdata[gat_pkg::CTRL_SYNC_BIT] = r.sync;
      rdata[gat_pkg::CTRL_BAND_LSB +: 2] = r.band;
    end
    else if (paddr_i == gat_pkg::ADDR_MODE)
    begin
      rdata[3:0] = r.mode;
    end
    else if (paddr_i == gat_pkg::ADDR_LEVEL)
    begin
      rdata[gat_pkg::LVL_LO_LSB +: 8] = r.lvl_lo;
      rdata[gat_pkg::LVL_HI_LSB +: 8] = r.lvl_hi;
    end
    else if (paddr_i == gat_pkg::ADDR_WIDTH)
    begin
      rdata[15:0] = r.width;
    end
    else if (paddr_i == gat_pkg::ADDR_TOTAL)
    begin
      rdata = r.total;
    end
    else if (paddr_i == gat_pkg::ADDR_STATUS)
    begin
      rdata[gat_pkg::STAT_GATE_BIT] = r.gate;
      rdata[gat_pkg::STAT_REC_BIT] = (r.st == gat_pkg::ST_REC) || (r.st == gat_pkg::ST_ALIGN);
      rdata[gat_pkg::STAT_DONE_BIT] = r.done;
      rdata[gat_pkg::STAT_OVF_BIT] = r.ovf;
      rdata[gat_pkg::STAT_BADMODE_BIT] = !mode_ok;
      rdata[gat_pkg::STAT_EMPTY_BIT] = empty;
      rdata[gat_pkg::STAT_FULL_BIT] = full;
    end
    else if (paddr_i == gat_pkg::ADDR_TS_LO)
    begin
      rdata = head.value[31:0];
    end
    else if (paddr_i == gat_pkg::ADDR_TS_HI)
    begin
      rdata[15:0] = head.value[gat_pkg::TS_W-1:32];
      rdata[gat_pkg::TS_HI_END_BIT] = head.is_end;
    end
    else if (paddr_i == gat_pkg::ADDR_TS_COUNT)
    begin
      rdata[16:0] = ts_count;
    end
  end

  always_comb
  begin
    n = r;
    push = 1'b0;
    push_data = '0;
    pop = 1'b0;
    n.rec_valid = 1'b0;
    n.pready = setup;
    if (setup)
    begin
      n.prdata = rdata;
      n.pslverr = !addr_hit(paddr_i);
    end
    // Popping the high half lets the host drain the store while recording runs.
    pop = access && !pwrite_i && (paddr_i == gat_pkg::ADDR_TS_HI) && !empty;
    // The counter advances on the base sample tick, which stays at the
    // non-interlaced rate even when samples are interleaved.
    if (sample_en_i)
    begin
      n.ts = r.ts + 48'h000000000001;
      n.dly = {r.dly[gat_pkg::PIPE-2:0], sample_i};
      n.cond_prev = cond;
      n.wcnt = cond ? wcnt_inc : 16'h0000;
      if (r.gate)
      begin
        n.glen = r.glen + 32'h00000001;
      end
    end
    if (start_ev)
    begin
      n.gate = 1'b1;
      n.glen = 32'h00000001;
      push = 1'b1;
      push_data.value = r.ts;
    end
    if (end_ev)
    begin
      n.gate = 1'b0;
    end
    if (!r.run)
    begin
      n.st = gat_pkg::ST_IDLE;
      n.gate = 1'b0;
    end
    else if (sample_en_i)
    begin
      case (r.st)
        gat_pkg::ST_IDLE:
        begin
          // Recording begins only at the gate event, never before it.
          if (start_ev)
          begin
            n.st = gat_pkg::ST_WAIT;
            n.seg = 32'h00000000;
            // The delay line gives PIPE samples of look-back for negative delays; two
            // ticks go to entering the recording state, so the wait is that much shorter.
            n.wait_cnt = 7'(delay + gat_pkg::PIPE_S - 7'sh02);
          end
        end
        gat_pkg::ST_WAIT:
        begin
          if (end_ev)
          begin
            n.st = gat_pkg::ST_IDLE;
            push = 1'b1;
            push_data.is_end = 1'b1;
            push_data.value = r.ts;
          end
          else if (r.wait_cnt == 7'h00)
          begin
            n.st = gat_pkg::ST_REC;
          end
          else
          begin
            n.wait_cnt = r.wait_cnt - 7'h01;
          end
        end
        gat_pkg::ST_REC, gat_pkg::ST_ALIGN:
        begin
          if ((r.st == gat_pkg::ST_ALIGN) &&
              (((r.seg[2:0] & gat_pkg::ALIGN_MASK) == 3'h0) || (r.seg >= r.limit)))
          begin
            n.st = gat_pkg::ST_IDLE;
            push = 1'b1;
            push_data.is_end = 1'b1;
            push_data.value = r.ts;
          end
          else
          begin
            n.rec_valid = 1'b1;
            n.rec_data = r.dly[gat_pkg::PIPE-1];
            n.seg = seg_inc;
            n.rec_total = tot_inc;
            if (end_ev)
            begin
              n.st = gat_pkg::ST_ALIGN;
              // The start delay eats into the gate, so the cap is length minus shortfall.
              n.limit = (r.glen > shortfall) ? r.glen - shortfall : 32'h00000000;
            end
            if (!r.fifo_mode && (tot_inc >= r.total))
            begin
              n.st = gat_pkg::ST_DONE;
              n.done = 1'b1;
              n.gate = 1'b0;
              push = 1'b1;
              push_data.is_end = 1'b1;
              push_data.value = r.ts;
            end
          end
        end
        gat_pkg::ST_DONE:
        begin
          n.gate = 1'b0;
        end
        default:
        begin
          n.st = gat_pkg::ST_IDLE;
        end
      endcase
    end
    if (access && pwrite_i)
    begin
      if (paddr_i == gat_pkg::ADDR_CTRL)
      begin
        n.gate_en = pwdata_i[gat_pkg::CTRL_GATE_BIT];
        n.fifo_mode = pwdata_i[gat_pkg::CTRL_FIFO_BIT];
        n.run = pwdata_i[gat_pkg::CTRL_RUN_BIT];
        n.two_ch = pwdata_i[gat_pkg::CTRL_TWO_CH_BIT];
        n.sync = pwdata_i[gat_pkg::CTRL_SYNC_BIT];
        n.band = pwdata_i[gat_pkg::CTRL_BAND_LSB +: 2];
        if (pwdata_i[gat_pkg::CTRL_RUN_BIT] && !r.run)
        begin
          n.done = 1'b0;
          n.rec_total = 32'h00000000;
        end
        if (pwdata_i[gat_pkg::CTRL_TS_RST_BIT])
        begin
          n.ts = '0;
        end
      end
      else if (paddr_i == gat_pkg::ADDR_MODE)
      begin
        n.mode = pwdata_i[3:0];
      end
      else if (paddr_i == gat_pkg::ADDR_LEVEL)
      begin
        n.lvl_lo = pwdata_i[gat_pkg::LVL_LO_LSB +: 8];
        n.lvl_hi = pwdata_i[gat_pkg::LVL_HI_LSB +: 8];
      end
      else if (paddr_i == gat_pkg::ADDR_WIDTH)
      begin
        n.width = pwdata_i[15:0];
      end
      else if (paddr_i == gat_pkg::ADDR_TOTAL)
      begin
        n.total = pwdata_i;
      end
      else if (paddr_i == gat_pkg::ADDR_STATUS)
      begin
        if (pwdata_i[gat_pkg::STAT_OVF_BIT])
        begin
          n.ovf = 1'b0;
        end
      end
    end
    // A new overflow in the clearing cycle wins over the clear.
    if (push && full)
    begin
      n.ovf = 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      r <= '0;
      r.st <= gat_pkg::ST_IDLE;
      r.lvl_lo <= gat_pkg::LVL_LO_RST;
      r.lvl_hi <= gat_pkg::LVL_HI_RST;
      r.width <= gat_pkg::WIDTH_RST;
      r.total <= gat_pkg::TOTAL_RST;
    end
    else
    begin
      r <= n;
    end
  end

  gat_ts_fifo u_ts_fifo (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .push_i(push),
    .push_data_i(push_data),
    .pop_i(pop),
    .head_o(head),
    .count_o(ts_count),
    .full_o(full),
    .empty_o(empty)
  );

  assign prdata_o = r.prdata;
  assign pready_o = r.pready;
  assign pslverr_o = r.pslverr;
  assign rec_valid_o = r.rec_valid;
  assign rec_data_o = r.rec_data;
  assign gate_o = r.gate;
  assign done_o = r.done;

endmodule

// *** core/gat_pkg.sv ***
// Package with register map, field layout, timing figures and types of the gated recorder.
package gat_pkg;

  // Register byte addresses.
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_MODE = 8'h04;
  localparam logic [7:0] ADDR_LEVEL = 8'h08;
  localparam logic [7:0] ADDR_WIDTH = 8'h0C;
  localparam logic [7:0] ADDR_TOTAL = 8'h10;
  localparam logic [7:0] ADDR_STATUS = 8'h14;
  localparam logic [7:0] ADDR_TS_LO = 8'h18;
  localparam logic [7:0] ADDR_TS_HI = 8'h1C;
  localparam logic [7:0] ADDR_TS_COUNT = 8'h20;

  // Control register fields, then level and timestamp high field positions.
  localparam int CTRL_GATE_BIT = 0;
  localparam int CTRL_FIFO_BIT = 1;
  localparam int CTRL_RUN_BIT = 2;
  localparam int CTRL_TWO_CH_BIT = 3;
  localparam int CTRL_SYNC_BIT = 4;
  localparam int CTRL_BAND_LSB = 5;
  localparam int CTRL_TS_RST_BIT = 7;
  localparam int LVL_LO_LSB = 0;
  localparam int LVL_HI_LSB = 8;
  localparam int TS_HI_END_BIT = 31;

  // Status register fields.
  localparam int STAT_GATE_BIT = 0;
  localparam int STAT_REC_BIT = 1;
  localparam int STAT_DONE_BIT = 2;
  localparam int STAT_OVF_BIT = 3;
  localparam int STAT_BADMODE_BIT = 4;
  localparam int STAT_EMPTY_BIT = 5;
  localparam int STAT_FULL_BIT = 6;

  // Reset values.
  localparam logic [7:0] LVL_LO_RST = 8'h80;
  localparam logic [7:0] LVL_HI_RST = 8'hC0;
  localparam logic [15:0] WIDTH_RST = 16'h0000;
  localparam logic [31:0] TOTAL_RST = 32'h00001000;

  // Sizes.
  localparam int TS_W = 48;
  localparam int TS_AW = 16;
  localparam logic [16:0] TS_DEPTH = 17'h10000;
  localparam int PIPE = 8;
  localparam logic signed [6:0] PIPE_S = 7'sh08;
  localparam logic [2:0] ALIGN_MASK = 3'h7;

  // Start delays in samples, one channel: below 10, 10 to 100, from 100 MS/s.
  localparam logic signed [6:0] SD_1_LO_EXT = 7'sh16;
  localparam logic signed [6:0] SD_1_LO_INT = 7'sh1F;
  localparam logic signed [6:0] SD_1_MID_EXT = 7'sh17;
  localparam logic signed [6:0] SD_1_MID_INT = 7'sh15;
  localparam logic signed [6:0] SD_1_HI_EXT = 7'sh10;
  localparam logic signed [6:0] SD_1_HI_INT = 7'sh20;
  // Two channels: below 5, from 5 MS/s.
  localparam logic signed [6:0] SD_2_LO_EXT = -7'sh05;
  localparam logic signed [6:0] SD_2_LO_INT = 7'sh05;
  localparam logic signed [6:0] SD_2_HI_EXT = 7'sh08;
  localparam logic signed [6:0] SD_2_HI_INT = 7'sh10;
  localparam logic signed [6:0] SD_SYNC_ADD = 7'sh02;

  // Samples lost per gate interval.
  localparam logic [31:0] SHORT_1_LO = 32'h0000000E;
  localparam logic [31:0] SHORT_1_HI = 32'h00000018;
  localparam logic [31:0] SHORT_2_LO = 32'h00000006;
  localparam logic [31:0] SHORT_2_HI = 32'h0000000C;

  typedef enum logic [3:0] {
    ext_rising_gate = 4'h0,
    ext_falling_gate = 4'h1,
    ext_high_width_gate = 4'h2,
    ext_low_width_gate = 4'h3,
    chan_rising_gate = 4'h4,
    chan_falling_gate = 4'h5,
    chan_above_width_gate = 4'h6,
    chan_below_width_gate = 4'h7,
    window_enter_gate = 4'h8,
    window_enter_width_gate = 4'h9,
    window_leave_gate = 4'hA,
    window_leave_width_gate = 4'hB
  } gat_mode_e;

  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_WAIT = 5'h02,
    ST_REC = 5'h04,
    ST_ALIGN = 5'h08,
    ST_DONE = 5'h10
  } gat_state_e;

  typedef struct packed {
    logic is_end;
    logic [TS_W-1:0] value;
  } gat_ts_s;

  typedef struct packed {
    logic [TS_AW-1:0] wr;
    logic [TS_AW-1:0] rd;
    logic [16:0] count;
  } gat_fifo_s;

  typedef struct packed {
    logic gate_en;
    logic fifo_mode;
    logic run;
    logic two_ch;
    logic sync;
    logic [1:0] band;
    logic [3:0] mode;
    logic [7:0] lvl_lo;
    logic [7:0] lvl_hi;
    logic [15:0] width;
    logic [31:0] total;
    logic ovf;
    logic [TS_W-1:0] ts;
    logic cond_prev;
    logic [15:0] wcnt;
    logic gate;
    gat_state_e st;
    logic [6:0] wait_cnt;
    logic [31:0] glen;
    logic [31:0] limit;
    logic [31:0] seg;
    logic [31:0] rec_total;
    logic done;
    logic [PIPE-1:0][7:0] dly;
    logic [7:0] rec_data;
    logic rec_valid;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } gat_core_s;

endpackage

// *** core/gat_ts_fifo.sv ***
// Timestamp first-in first-out store built from flip-flops.
`timescale 1ns/1ps
module gat_ts_fifo (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic push_i,
  input wire gat_pkg::gat_ts_s push_data_i,
  input wire logic pop_i,
  output gat_pkg::gat_ts_s head_o,
  output logic [16:0] count_o,
  output logic full_o,
  output logic empty_o
);

  gat_pkg::gat_ts_s mem [2**gat_pkg::TS_AW];
  gat_pkg::gat_fifo_s r;
  gat_pkg::gat_fifo_s n;
  logic do_push;
  logic do_pop;

  assign full_o = (r.count == gat_pkg::TS_DEPTH);
  assign empty_o = (r.count == 17'h00000);
  assign do_push = push_i && !full_o;
  assign do_pop = pop_i && !empty_o;
  assign head_o = mem[r.rd];
  assign count_o = r.count;

  always_comb
  begin
    n = r;
    if (do_push)
    begin
      n.wr = r.wr + 16'h0001;
    end
    if (do_pop)
    begin
      n.rd = r.rd + 16'h0001;
    end
    if (do_push && !do_pop)
    begin
      n.count = r.count + 17'h00001;
    end
    else if (do_pop && !do_push)
    begin
      n.count = r.count - 17'h00001;
    end
  end

  // Entries are never overwritten: a push into a full store is dropped.
  always_ff @(posedge clk_i)
  begin
    if (do_push)
    begin
      mem[r.wr] <= push_data_i;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      r <= '0;
    end
    else
    begin
      r <= n;
    end
  end

endmodule

// *** sim/gat_recorder_checker.sv ***
// Port timing checker for the gated recorder.
`timescale 1ns/1ps
module gat_recorder_checker (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire logic sample_en_i,
  input wire logic rec_valid_o,
  input wire logic gate_o,
  input wire logic done_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  logic [3:0] tail_reg;
  // Saturates so that a runaway tail cannot wrap back into the legal range.
  always_ff @(posedge clk_i or negedge rstn_i)
    if (!rstn_i) tail_reg <= 4'h0;
    else if (gate_o) tail_reg <= 4'h0;
    else if (rec_valid_o && tail_reg != 4'hF) tail_reg <= tail_reg + 4'h1;
  ready_wait_a: assert property (psel_i && !penable_i |=> pready_o)
    else $error("access phase not answered at once");
  ready_pulse_a: assert property (pready_o |-> (psel_i && penable_i) ##1 !pready_o)
    else $error("pready outside one access cycle");
  err_unmapped_a: assert property (psel_i && !penable_i && paddr_i > gat_pkg::ADDR_TS_COUNT
    |=> pslverr_o && pready_o)
    else $error("unmapped address not refused");
  err_zero_a: assert property (pslverr_o && !pwrite_i |-> prdata_o == 32'h00000000)
    else $error("refused read returns data");
  rec_tick_a: assert property (rec_valid_o |-> $past(sample_en_i))
    else $error("sample recorded without a tick");
  gate_tick_a: assert property ($rose(gate_o) |-> $past(sample_en_i))
    else $error("gate opened without a tick");
  tail_limit_a: assert property (tail_reg <= 4'h8)
    else $error("too many samples after gate end");
  done_quiet_a: assert property (done_o && $past(done_o) |-> !rec_valid_o)
    else $error("recording after total count");
endmodule
bind gat_recorder gat_recorder_checker i_gat_recorder_checker (
  .clk_i(clk_i),
  .rstn_i(rstn_i),
  .psel_i(psel_i),
  .penable_i(penable_i),
  .pwrite_i(pwrite_i),
  .paddr_i(paddr_i),
  .prdata_o(prdata_o),
  .pready_o(pready_o),
  .pslverr_o(pslverr_o),
  .sample_en_i(sample_en_i),
  .rec_valid_o(rec_valid_o),
  .gate_o(gate_o),
  .done_o(done_o)
);

// *** sim/gat_src.sv ***
// Model of the sample stream and external trigger source outside the recorder.
`timescale 1ns/1ps
module gat_src (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic ext_req_i,
  output logic sample_en_o,
  output logic [7:0] sample_o,
  output logic ext_trig_o
);
  // A ramp crosses every level once a lap, so channel modes need no extra stimulus.
  always_ff @(posedge clk_i or negedge rstn_i)
    if (!rstn_i)
    begin
      sample_en_o <= 1'b0;
      sample_o <= 8'h00;
      ext_trig_o <= 1'b0;
    end
    else
    begin
      sample_en_o <= !sample_en_o;
      if (sample_en_o) sample_o <= sample_o + 8'h01;
      ext_trig_o <= ext_req_i;
    end
endmodule

// *** sim/tb_gated_acquisition_timestamp.sv ***
// Self-checking testbench of the gated recorder.
`timescale 1ns/1ps
module tb_gated_acquisition_timestamp;
  logic clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic psel_i = 1'b0;
  logic penable_i = 1'b0;
  logic pwrite_i = 1'b0;
  logic [7:0] paddr_i = 8'h00;
  logic [31:0] pwdata_i = 32'h00000000;
  logic ext_req = 1'b0;
  logic sample_en_i, ext_trig_i, rec_valid_o, gate_o, done_o, pready_o, pslverr_o, err, gate_q;
  logic [7:0] sample_i, rec_data_o, first_data, s0, last_s;
  logic [31:0] prdata_o, rd, ts_a;
  int num_errors = 0;
  int total_checks = 0;
  int rec_cnt = 0;
  initial forever #12.5 clk_i = ~clk_i;
  gat_recorder i_gat_recorder (.clk_i(clk_i), .rstn_i(rstn_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .sample_en_i(sample_en_i), .sample_i(sample_i), .ext_trig_i(ext_trig_i),
    .rec_valid_o(rec_valid_o), .rec_data_o(rec_data_o), .gate_o(gate_o), .done_o(done_o));
  gat_src i_gat_src (.clk_i(clk_i), .rstn_i(rstn_i), .ext_req_i(ext_req),
    .sample_en_o(sample_en_i), .sample_o(sample_i), .ext_trig_o(ext_trig_i));
  always @(posedge clk_i)
  begin
    // The opening tick is the last sample tick before gate_o is first seen high.
    if (gate_o === 1'b1 && gate_q !== 1'b1) s0 = last_s;
    if (sample_en_i === 1'b1) last_s = sample_i;
    gate_q = gate_o;
    if (rec_valid_o === 1'b1 && rec_cnt == 0) first_data = rec_data_o;
    if (rec_valid_o === 1'b1) rec_cnt = rec_cnt + 1;
  end
  task automatic finish_test;
    if (num_errors == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    @(posedge clk_i);
    while (pready_o !== 1'b1)
    begin
      @(posedge clk_i);
    end
    rd = prdata_o;
    err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask
  task automatic wait_gate(input logic lvl);
    int n;
    n = 0;
    while (gate_o !== lvl && n < 1200)
    begin
      @(posedge clk_i);
      n++;
    end
    chk({31'h0, gate_o}, {31'h0, lvl});
  endtask
  // A nonzero count also checks the number of recorded samples, set by end-of-gate alignment or by the total count.
  task automatic run_case(input logic [31:0] ctrl, input logic [3:0] mode,
    input logic [7:0] dly, input int cnt);
    apb(1'b1, gat_pkg::ADDR_MODE, {28'h0, mode});
    rec_cnt = 0;
    apb(1'b1, gat_pkg::ADDR_CTRL, ctrl);
    if (mode < 4'h4)
    begin
      ext_req <= 1'b1;
      repeat (200) @(posedge clk_i);
      ext_req <= 1'b0;
    end
    else
    begin
      wait_gate(1'b1);
      wait_gate(1'b0);
    end
    repeat (40) @(posedge clk_i);
    chk({24'h0, first_data - s0}, {24'h0, dly});
    if (cnt > 0) chk(rec_cnt, cnt);
    if (!ctrl[1]) chk({31'h0, done_o}, 32'h00000001);
    apb(1'b1, gat_pkg::ADDR_CTRL, 32'h00000000);
  endtask
  initial
  begin
    fork
      begin
        repeat (5) @(posedge clk_i);
        rstn_i <= 1'b1;
      end
      begin
        repeat (30000) @(posedge clk_i);
        num_errors++;
        finish_test;
      end
    join_none
    wait (rstn_i === 1'b1);
    apb(1'b0, gat_pkg::ADDR_LEVEL, 32'h0);
    chk(rd, 32'h0000C080);
    apb(1'b0, gat_pkg::ADDR_STATUS, 32'h0);
    chk(rd & 32'h0000007F, 32'h00000020);
    apb(1'b0, 8'h40, 32'h0);
    chk({err, rd[30:0]}, 32'h80000000);
    run_case(32'h00000007, 4'h0, 8'h16, 72);
    apb(1'b0, gat_pkg::ADDR_TS_COUNT, 32'h0);
    chk(rd, 32'h00000002);
    apb(1'b0, gat_pkg::ADDR_TS_LO, 32'h0);
    ts_a = rd;
    apb(1'b0, gat_pkg::ADDR_TS_HI, 32'h0);
    chk({31'h0, rd[31]}, 32'h00000000);
    apb(1'b0, gat_pkg::ADDR_TS_LO, 32'h0);
    chk({31'h0, rd > ts_a}, 32'h00000001);
    apb(1'b0, gat_pkg::ADDR_TS_HI, 32'h0);
    chk({31'h0, rd[31]}, 32'h00000001);
    run_case(32'h00000017, 4'h0, 8'h18, 72);
    run_case(32'h0000000F, 4'h0, 8'hFB, 0);
    run_case(32'h00000007, 4'h4, 8'h1F, 0);
    apb(1'b1, gat_pkg::ADDR_WIDTH, 32'h00000020);
    run_case(32'h00000007, 4'h2, 8'h16, 40);
    apb(1'b1, gat_pkg::ADDR_TOTAL, 32'h00000010);
    run_case(32'h00000005, 4'h0, 8'h16, 16);
    apb(1'b1, gat_pkg::ADDR_MODE, 32'h0000000C);
    apb(1'b1, gat_pkg::ADDR_CTRL, 32'h00000005);
    apb(1'b0, gat_pkg::ADDR_STATUS, 32'h0);
    chk(rd & 32'h00000010, 32'h00000010);
    finish_test;
  end
endmodule
